// ---- inc/afp_pkg.sv ----
// Package for the amplifier fault protection and mode control block
package afp_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_IDLE   = 8'h10;

  // Event bit positions in the interrupt status and mask registers
  localparam int EV_OC   = 0;
  localparam int EV_OT   = 1;
  localparam int EV_DC   = 2;
  localparam int EV_UV   = 3;
  localparam int EV_OV   = 4;
  localparam int EV_W    = 5;

  // Control field positions
  localparam int CTRL_SOFT_SD = 0;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [5:0]  MASK_RST = 6'h00;

  // PWM resolution and duty thresholds, in counts of a 256-step period
  localparam int          PWM_W      = 8;
  localparam logic [7:0]  DUTY_HALF  = 8'h80;
  localparam logic [7:0]  DUTY_DC    = 8'h9a;
  localparam logic [7:0]  DUTY_IDLE  = 8'h26;

  // Timing
  localparam int CLK_MHZ       = 200;
  localparam int POWERUP_MS    = 10;
  localparam int DC_DETECT_MS  = 420;
  localparam int POWERUP_CYC   = POWERUP_MS * CLK_MHZ * 1000;
  localparam int DC_DETECT_CYC = DC_DETECT_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0]
  {
    ST_POWERUP = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_ACTIVE  = 2'b10
  } afp_state_type;

  // Analog comparator and detector flags, coming in from another domain
  typedef struct packed
  {
    logic over_current;
    logic over_temp;
    logic under_volt;
    logic over_volt;
  } afp_sense_type;

  // Bridge drive for one channel
  typedef struct packed
  {
    logic out_pos_leg;
    logic out_neg_leg;
  } afp_leg_type;

endpackage : afp_pkg

// ---- verilog/afp_ctrl.sv ----
// Amplifier fault protection, mode selection and PWM leg control
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module afp_ctrl
  import afp_pkg::*;
#(
  parameter int POWERUP_CYCLES   = POWERUP_CYC,
  parameter int DC_DETECT_CYCLES = DC_DETECT_CYC
)
(
  // Clock, reset and enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 clk_en_in,
  // APB slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // Pins and analog sense flags
  input  wire logic                 shutdown_n_in,
  input  wire logic                 modulation_select_in,
  input  wire logic                 left_inputs_grounded_in,
  input  wire afp_pkg::afp_sense_type sense_in,
  // Signal demand per channel, signed
  input  wire logic signed [PWM_W-1:0] demand_left_in,
  input  wire logic signed [PWM_W-1:0] demand_right_in,
  // Outputs
  output logic                      fault_flag_n_out,
  output logic                      outputs_hiz_out,
  output logic                      low_current_out,
  output logic                      parallel_bridge_mono_out,
  output afp_pkg::afp_leg_type      leg_left_out,
  output afp_pkg::afp_leg_type      leg_right_out,
  output logic                      irq_out
);

  // Two flip-flop synchronisers for all asynchronous pins
  logic [7:0] sync1_reg, sync2_reg;
  logic [7:0] sync1_next, sync2_next;
  logic       sd_n, scheme_sel, lgnd;
  afp_sense_type sense;

  always_comb
  begin
    sync1_next = {shutdown_n_in, modulation_select_in,
                  left_inputs_grounded_in, 1'b0, sense_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else if (clk_en_in)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign sd_n   = sync2_reg[7];
  assign scheme_sel = sync2_reg[6];
  assign lgnd   = sync2_reg[5];
  assign sense  = sync2_reg[3:0];

  function automatic logic [PWM_W-1:0] clip_duty(input int v);
    if (v > 255)
      clip_duty = 8'hff;
    else if (v < 0)
      clip_duty = 8'h00;
    else
      clip_duty = v[PWM_W-1:0];
  endfunction : clip_duty

  // Main control state
  afp_state_type state_reg, state_next;
  logic [31:0] pu_cnt_reg, pu_cnt_next;
  logic [31:0] dc_cnt_reg [2];
  logic [31:0] dc_cnt_next [2];
  logic [1:0]  dc_pol_reg [2];
  logic [1:0]  dc_pol_next [2];
  logic        oc_reg, ot_reg, dc_reg;
  logic        oc_next, ot_next, dc_next;
  logic        mono_reg, mono_next;
  logic        scheme_sel_reg, scheme_sel_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [5:0]  irq_reg, irq_next;
  logic [5:0]  mask_reg, mask_next;
  logic [PWM_W-1:0] cnt_reg, cnt_next;
  logic [PWM_W-1:0] dp [2];
  logic [PWM_W-1:0] dn [2];
  afp_leg_type legs [2];
  logic        latched, supply_bad, sd_eff, run;
  logic        rd_acc, wr_acc;
  logic [5:0]  ev;
  logic [31:0] rdata;
  logic        addr_ok;

  assign rd_acc = psel_in && penable_in && !pwrite_in;
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign latched = oc_reg || ot_reg || dc_reg;
  assign supply_bad = sense.under_volt || sense.over_volt;
  assign sd_eff = !sd_n || ctrl_reg[CTRL_SOFT_SD];
  // Shutdown gates the bridge at once, even in the cycle power-up ends
  assign run = (state_reg == ST_ACTIVE) && !latched && !supply_bad
               && !sd_eff;

  // Leg duty computation for each channel
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      int d;
      d = mono_reg ? int'(demand_right_in) :
          (c == 0 ? int'(demand_left_in) : int'(demand_right_in));
      if (!scheme_sel_reg)
      begin
        dp[c] = clip_duty(int'(DUTY_HALF) + d);
        dn[c] = clip_duty(int'(DUTY_HALF) - d);
      end
      else
      begin
        // Falling leg rails to ground: fewer switching losses, some THD
        dp[c] = (d < 0) ? 8'h00 : clip_duty(int'(DUTY_IDLE) + d);
        dn[c] = (d > 0) ? 8'h00 : clip_duty(int'(DUTY_IDLE) - d);
      end
    end
  end

  always_comb
  begin
    state_next  = state_reg;
    pu_cnt_next = pu_cnt_reg;
    oc_next     = oc_reg;
    ot_next     = ot_reg;
    dc_next     = dc_reg;
    mono_next   = mono_reg;
    scheme_sel_next = scheme_sel;
    cnt_next    = cnt_reg + 8'h01;
    ctrl_next   = ctrl_reg;
    mask_next   = mask_reg;
    ev          = 6'h00;
    for (int c = 0; c < 2; c++)
    begin
      dc_cnt_next[c] = dc_cnt_reg[c];
      dc_pol_next[c] = dc_pol_reg[c];
    end
    case (state_reg)
      ST_POWERUP:
      begin
        // Inputs charge their coupling capacitors meanwhile
        if (pu_cnt_reg >= POWERUP_CYCLES - 1)
        begin
          mono_next = lgnd;
          state_next = ST_ACTIVE;
        end
        else
          pu_cnt_next = pu_cnt_reg + 32'h1;
      end
      ST_SHUTDOWN:
      begin
        if (!sd_eff)
          state_next = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (sd_eff)
          state_next = ST_SHUTDOWN;
      end
      default:
        state_next = ST_POWERUP;
    endcase
    if (sd_eff)
    begin
      oc_next = 1'b0;
      ot_next = 1'b0;
      dc_next = 1'b0;
      for (int c = 0; c < 2; c++)
        dc_cnt_next[c] = 32'h0;
    end
    else if (state_reg == ST_ACTIVE)
    begin
      if (sense.over_current)
      begin
        oc_next = 1'b1;
        ev[EV_OC] = !oc_reg;
      end
      if (sense.over_temp)
      begin
        ot_next = 1'b1;
        ev[EV_OT] = !ot_reg;
      end
      for (int c = 0; c < 2; c++)
      begin
        logic [1:0] pol;
        pol = {dp[c] > DUTY_DC, dn[c] > DUTY_DC};
        if (!run || pol == 2'b00 || pol != dc_pol_reg[c])
          dc_cnt_next[c] = 32'h0;
        else if (dc_cnt_reg[c] >= DC_DETECT_CYCLES)
        begin
          dc_next = 1'b1;
          ev[EV_DC] = !dc_reg;
        end
        else
          dc_cnt_next[c] = dc_cnt_reg[c] + 32'h1;
        dc_pol_next[c] = pol;
      end
    end
    ev[EV_UV] = sense.under_volt && !irq_reg[EV_UV];
    ev[EV_OV] = sense.over_volt && !irq_reg[EV_OV];
    ev[EV_W]  = 1'b0;
    if (wr_acc && paddr_in == OFS_CTRL)
      ctrl_next = pwdata_in;
    if (wr_acc && paddr_in == OFS_MASK)
      mask_next = pwdata_in[5:0];
    // Read clears, but a new event in the same cycle survives
    irq_next = ((rd_acc && paddr_in == OFS_IRQ) ? 6'h00 : irq_reg) | ev;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg  <= ST_POWERUP;
      pu_cnt_reg <= 32'h0;
      oc_reg     <= 1'b0;
      ot_reg     <= 1'b0;
      dc_reg     <= 1'b0;
      mono_reg   <= 1'b0;
      scheme_sel_reg <= 1'b0;
      cnt_reg    <= 8'h00;
      ctrl_reg   <= CTRL_RST;
      mask_reg   <= MASK_RST;
      irq_reg    <= 6'h00;
      for (int c = 0; c < 2; c++)
      begin
        dc_cnt_reg[c] <= 32'h0;
        dc_pol_reg[c] <= 2'b00;
      end
    end
    else if (clk_en_in)
    begin
      state_reg  <= state_next;
      pu_cnt_reg <= pu_cnt_next;
      oc_reg     <= oc_next;
      ot_reg     <= ot_next;
      dc_reg     <= dc_next;
      mono_reg   <= mono_next;
      scheme_sel_reg <= scheme_sel_next;
      cnt_reg    <= cnt_next;
      ctrl_reg   <= ctrl_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      for (int c = 0; c < 2; c++)
      begin
        dc_cnt_reg[c] <= dc_cnt_next[c];
        dc_pol_reg[c] <= dc_pol_next[c];
      end
    end
  end

  // Registered pin outputs
  logic fault_n_reg, hiz_reg, lowi_reg;
  afp_leg_type legl_reg, legr_reg;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      legs[c].out_pos_leg = run && (cnt_reg < dp[c]);
      legs[c].out_neg_leg = run && (cnt_reg < dn[c]);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fault_n_reg <= 1'b1;
      hiz_reg     <= 1'b1;
      lowi_reg    <= 1'b1;
      legl_reg    <= 2'b00;
      legr_reg    <= 2'b00;
    end
    else if (clk_en_in)
    begin
      fault_n_reg <= !latched;
      hiz_reg     <= !run;
      lowi_reg    <= state_reg != ST_ACTIVE;
      legl_reg    <= legs[0];
      legr_reg    <= legs[1];
    end
  end

  // APB read mux, zero wait states; unmapped addresses flag an error
  always_comb
  begin
    rdata   = 32'h0;
    addr_ok = 1'b1;
    case (paddr_in)
      OFS_CTRL:   rdata = ctrl_reg;
      OFS_STATUS: rdata = {24'h0, mono_reg, scheme_sel_reg, state_reg,
                           dc_reg, ot_reg, oc_reg, !run};
      OFS_IRQ:    rdata = {26'h0, irq_reg};
      OFS_MASK:   rdata = {26'h0, mask_reg};
      default:    addr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    prdata_out  = rdata;
    pready_out  = 1'b1;
    pslverr_out = psel_in && penable_in && !addr_ok;
  end

  assign fault_flag_n_out         = fault_n_reg;
  assign outputs_hiz_out          = hiz_reg;
  assign low_current_out          = lowi_reg;
  assign parallel_bridge_mono_out = mono_reg;
  assign leg_left_out             = legl_reg;
  assign leg_right_out            = legr_reg;
  assign irq_out                  = |(irq_reg & mask_reg);

endmodule : afp_ctrl

// ---- test/afp_ctrl_asserts.sv ----
// Checker for the amplifier protection block
`timescale 1ns/1ps
module afp_ctrl_chk
  import afp_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
  // Clock and reset
  input wire logic                  sys_clk_in,
  input wire logic                  rst_in,
  // Watched pins
  input wire logic                  shutdown_n_in,
  input wire afp_pkg::afp_sense_type sense_in,
  input wire logic                  fault_flag_n_out,
  input wire logic                  outputs_hiz_out,
  input wire logic                  low_current_out
);
  int cnt_reg;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // Saturates so the start-up window check costs one compare
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= 0;
    else if (cnt_reg < POWERUP_CYCLES)
      cnt_reg <= cnt_reg + 1;
  end
  // Shutdown high long enough for the synchroniser to agree
  sequence run_s(s);
    shutdown_n_in[*4] ##0 (s && !outputs_hiz_out) ##1 (s && shutdown_n_in)[*4];
  endsequence
  trip_oc_a: assert property (run_s(sense_in.over_current) |=> !fault_flag_n_out)
    else $error("over-current not flagged");
  trip_ot_a: assert property (run_s(sense_in.over_temp) |=> !fault_flag_n_out)
    else $error("over-temperature not flagged");
  fault_hiz_a: assert property (!fault_flag_n_out |-> outputs_hiz_out)
    else $error("fault flagged with outputs driven");
  latch_hold_a: assert property (shutdown_n_in[*5] ##0 !fault_flag_n_out |=> !fault_flag_n_out)
    else $error("latched fault released");
  uv_hiz_a: assert property (sense_in.under_volt[*4] |=> outputs_hiz_out)
    else $error("undervoltage left outputs driven");
  ov_hiz_a: assert property (sense_in.over_volt[*4] |=> outputs_hiz_out)
    else $error("overvoltage left outputs driven");
  sd_mute_a: assert property (!shutdown_n_in[*5] |=> outputs_hiz_out && low_current_out)
    else $error("shutdown did not mute");
  sd_clear_a: assert property (!shutdown_n_in[*8] |=> fault_flag_n_out)
    else $error("shutdown did not clear latch");
  powerup_a: assert property (cnt_reg < POWERUP_CYCLES |-> outputs_hiz_out)
    else $error("outputs active during start-up");
endmodule : afp_ctrl_chk

bind afp_ctrl afp_ctrl_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_afp_ctrl_chk
(
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .shutdown_n_in(shutdown_n_in),
  .sense_in(sense_in), .fault_flag_n_out(fault_flag_n_out),
  .outputs_hiz_out(outputs_hiz_out), .low_current_out(low_current_out)
);

// ---- test/afp_host.sv ----
// Host controller model driving shutdown and watching the fault flag
`timescale 1ns/1ps
module afp_host
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Bench control
  input  wire logic settled_in,
  input  wire logic auto_recover_in,
  // Device pins
  input  wire logic fault_flag_n_in,
  output logic      shutdown_n_out
);
  logic sd_reg;
  logic sd_next;
  always_comb
  begin
    sd_next = settled_in;
    if (auto_recover_in && fault_flag_n_in !== 1'b1)
      sd_next = 1'b0;
  end
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sd_reg <= 1'b0;
    else
      sd_reg <= sd_next;
  end
  assign shutdown_n_out = sd_reg;
endmodule : afp_host

// ---- test/afp_ctrl_tb_top.sv ----
// Testbench for the amplifier protection block
`timescale 1ns/1ps
module afp_ctrl_tb_top;
  import afp_pkg::*;
  localparam int PU = 20;
  localparam int DC = 30;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, msel = 0, gnd = 0;
  logic settled = 0, autor = 0, pready, pslverr, sd_n, er;
  logic flag_n, hiz, lowc, mono, irq;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic signed [7:0] dl = 0, dr = 0;
  afp_sense_type sense = '0;
  afp_leg_type ll, lr;
  int miscompares = 0, n_compared = 0, cyc = 0, nw, np, nn, ne;

  always #2.5 clk = ~clk;

  afp_ctrl #(.POWERUP_CYCLES(PU), .DC_DETECT_CYCLES(DC)) u_afp_ctrl
  (
    .sys_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .shutdown_n_in(sd_n), .modulation_select_in(msel),
    .left_inputs_grounded_in(gnd), .sense_in(sense), .demand_left_in(dl),
    .demand_right_in(dr), .fault_flag_n_out(flag_n),
    .outputs_hiz_out(hiz), .low_current_out(lowc),
    .parallel_bridge_mono_out(mono), .leg_left_out(ll),
    .leg_right_out(lr), .irq_out(irq)
  );
  afp_host u_afp_host
  (
    .sys_clk_in(clk), .rst_in(rst), .settled_in(settled),
    .auto_recover_in(autor), .fault_flag_n_in(flag_n), .shutdown_n_out(sd_n)
  );

  task tally_and_finish;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chb

  task cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; er = pslverr;
    psel <= 0; pen <= 0;
  endtask : apb

  // Bounded wait; s picks the outputs_hiz pin, else the fault flag
  task wt(input logic s, input logic v);
    nw = 0;
    while ((s ? hiz : flag_n) !== v && nw < 20000)
    begin
      @(posedge clk);
      nw++;
    end
    chb(nw < 20000, 1);
  endtask : wt

  task duty;
    np = 0; nn = 0; ne = 0;
    repeat (256)
    begin
      @(posedge clk);
      np += int'(ll.out_pos_leg); nn += int'(ll.out_neg_leg);
      ne += int'(ll.out_pos_leg != ll.out_neg_leg);
    end
  endtask : duty

  task do_reset(input logic g);
    rst <= 1; settled <= 0; gnd <= g;
    cy(8);
    rst <= 0;
    cy(3);
    settled <= 1;
    wt(1, 0);
    chb(nw + 3 >= PU, 1);
    chb(mono, g);
    gnd <= 0;
  endtask : do_reset

  task t_latched;
    autor <= 1;
    sense.over_current <= 1;
    wt(0, 0);
    chb(hiz, 1);
    sense.over_current <= 0;
    wt(0, 1);
    wt(1, 0);
    autor <= 0;
    sense.over_temp <= 1;
    wt(0, 0);
    sense.over_temp <= 0;
    cy(40);
    chb(flag_n, 0);
    chb(hiz, 1);
    settled <= 0;
    cy(10);
    chb(lowc, 1);
    settled <= 1;
    wt(0, 1);
    wt(1, 0);
  endtask : t_latched

  task t_supply;
    for (int i = 0; i < 2; i++)
    begin
      if (i == 0) sense.under_volt <= 1;
      else sense.over_volt <= 1;
      cy(10);
      chb(hiz, 1);
      chb(flag_n, 1);
      sense.under_volt <= 0; sense.over_volt <= 0;
      wt(1, 0);
    end
  endtask : t_supply

  // Mono drives both bridges from the right demand
  task t_mono;
    dl <= 0; dr <= 16; cy(300); duty;
    chb(np > 128 && nn < 128, 1);
    chb(lr == ll, 1);
    dr <= 0;
  endtask : t_mono

  task t_regs;
    apb(0, OFS_STATUS, 0); chk(rd, 32'ha0);
    apb(0, OFS_CTRL, 0); chk(rd, CTRL_RST);
    apb(0, OFS_MASK, 0); chk(rd, {26'h0, MASK_RST});
    chb(irq, 0);
    apb(1, OFS_MASK, 32'h1f); cy(2); chb(irq, 1);
    apb(0, OFS_IRQ, 0); chk(rd, 32'h1b);
    cy(2); chb(irq, 0);
    apb(0, OFS_IRQ, 0); chk(rd, 0);
    apb(0, OFS_IDLE, 0); chb(er, 1); chk(rd, 0);
  endtask : t_regs

  task t_pwm;
    dl <= 0; cy(300); duty; chk(ne, 0);
    dl <= 16; cy(300); duty; chb(np > 128 && nn < 128, 1);
    dl <= -16; cy(300); duty; chb(np < 128 && nn > 128, 1);
    msel <= 1; dl <= 0; cy(300); duty;
    chk(np, {24'h0, DUTY_IDLE}); chk(nn, {24'h0, DUTY_IDLE});
    dl <= 16; cy(300); duty; chb((np == 0) != (nn == 0), 1);
  endtask : t_pwm

  task t_dc;
    msel <= 0; dl <= 120;
    wt(0, 0);
    chb(nw >= DC, 1);
    chb(hiz, 1);
    dl <= 0;
    apb(0, OFS_IRQ, 0); chk(rd, 32'h04);
  endtask : t_dc

  initial
  begin
    do_reset(1);
    t_latched;
    t_supply;
    t_mono;
    t_regs;
    do_reset(0);
    t_pwm;
    t_dc;
    tally_and_finish;
  end
endmodule : afp_ctrl_tb_top
